/* File: pkg/dopu_consts.svh */
// Purpose: constants of the operand and pointer unit
// Assumes: included by bare name
// Notes: widths, counts, field positions and reset values only
`ifndef DOPU_CONSTS_SVH
`define DOPU_CONSTS_SVH
`define DOPU_DATA_W 16
`define DOPU_ACC_W 40
`define DOPU_NUM_REGS 8
`define DOPU_NUM_PTRS 8
`define DOPU_PTR_W 16
`define DOPU_PTR_X_LAST 3
`define DOPU_INSN_W 32
`define DOPU_RESET_DATA 16'h0000
`define DOPU_RESET_ACC 40'h0000000000
`endif

/* File: pkg/dopu_pkg.sv */
// Purpose: types of the operand and pointer unit
// Assumes: nothing
// Notes: operation and pointer-mode encodings
package dopu_pkg;
  typedef enum logic [3:0] {
    DOPU_OP_NOP = 4'h0,
    DOPU_OP_MAC_ADD = 4'h1,
    DOPU_OP_MAC_SUB = 4'h2,
    DOPU_OP_MUL = 4'h3,
    DOPU_OP_ADD = 4'h4,
    DOPU_OP_SUB = 4'h5,
    DOPU_OP_SRA = 4'h6,
    DOPU_OP_SRL = 4'h7,
    DOPU_OP_SLL = 4'h8,
    DOPU_OP_NEG = 4'h9,
    DOPU_OP_INC = 4'hA,
    DOPU_OP_LOAD = 4'hB,
    DOPU_OP_STORE = 4'hC,
    DOPU_OP_MOVE = 4'hD,
    DOPU_OP_SETI = 4'hE,
    DOPU_OP_PMOD = 4'hF
  } dopu_op_t;
  typedef enum logic [2:0] {
    DOPU_PM_PLAIN = 3'h0,
    DOPU_PM_INC = 3'h1,
    DOPU_PM_DEC = 3'h2,
    DOPU_PM_INDEX = 3'h3,
    DOPU_PM_MODULO = 3'h4,
    DOPU_PM_BITREV = 3'h5
  } dopu_pmode_t;
  typedef enum logic [1:0] {
    DOPU_SEL_GPR = 2'h0,
    DOPU_SEL_PTR = 2'h1,
    DOPU_SEL_IDX = 2'h2,
    DOPU_SEL_MOD = 2'h3
  } dopu_dest_t;
endpackage

/* File: src/dopu_core.sv */
// Purpose: operand datapath and data-pointer modification unit
// Assumes: one decoded instruction per cycle, memory answers combinationally
// Notes: accumulators kept 40 bits wide; store data and address registered
// Operation
// (RL1) three-operand ops run on the multiply-accumulator with three registers
// (RL2) two-operand ops use mac, arithmetic unit or shifter; some take immediate
// (RL3) single-operand ops run on the arithmetic unit with one register
// (RL4) load/store move 16-bit words between memory and any register; here general registers only
// (RL5) register transfer copies one register into another
// (RL6) immediate setting loads general registers or pointer unit registers
// (RL7) eight pointers with index; 0-3 use x modulo, 4-7 y modulo
// (RL8) pointer updated after access, visible to the next instruction
// (RL9) plain form accesses at the pointer, pointer unchanged
// (RL10) post increment, decrement, or add matching index register
// (RL11) modulo mode: low part plus index mod (modulo+1), high part kept
// (RL12) bit-reversed mode accesses reversed address, then adds index
// (RL13) immediate modify adds instruction constant to any pointer
// (RL14) overflow-affecting ops set overflow flag on overflow; others never; shifts never set it here
// (RL15) overflow flag is sticky; no overflow leaves it unchanged
// (RL16) instructions are 32 bits, completing in one clock
// (RL17) pointer arithmetic wraps silently, no flag
`timescale 1ns/1ps
`include "dopu_consts.svh"
module dopu_core #(
  parameter int DATA_W = `DOPU_DATA_W,
  parameter int ACC_W = `DOPU_ACC_W,
  parameter int PTR_W = `DOPU_PTR_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic insn_valid,
  input wire dopu_pkg::dopu_op_t op,
  input wire logic affects_ov,
  input wire logic [2:0] dst_sel,
  input wire logic [2:0] src_a_sel,
  input wire logic [2:0] src_b_sel,
  input wire logic use_imm,
  input wire logic [DATA_W-1:0] imm,
  input wire dopu_pkg::dopu_dest_t seti_dest,
  input wire logic [2:0] ptr_sel,
  input wire logic seti_mod_y,
  input wire dopu_pkg::dopu_pmode_t pmode,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic [PTR_W-1:0] mem_addr,
  output logic mem_y_space,
  output logic mem_we,
  output logic [DATA_W-1:0] mem_wdata,
  output logic overflow_flag,
  output logic [ACC_W-1:0] result
);
  import dopu_pkg::*;

  localparam int NR = `DOPU_NUM_REGS;
  localparam int NP = `DOPU_NUM_PTRS;

  logic [ACC_W-1:0] gpr_q [NR];
  logic [PTR_W-1:0] address_pointer_reg [NP];
  logic [PTR_W-1:0] pointer_index_reg [NP];
  logic [PTR_W-1:0] x_modulo_reg;
  logic [PTR_W-1:0] y_modulo_reg;
  logic overflow_flag_q;
  logic [PTR_W-1:0] mem_addr_q;
  logic mem_y_q;
  logic mem_we_q;
  logic [DATA_W-1:0] mem_wdata_q;
  logic [ACC_W-1:0] result_q;

  // operand fetch; high half feeds the multiplier
  wire [ACC_W-1:0] opa = gpr_q[src_a_sel];
  wire [ACC_W-1:0] reg_b = gpr_q[src_b_sel];
  wire [ACC_W-1:0] imm_ext = {{(ACC_W-DATA_W){imm[DATA_W-1]}}, imm};
  wire [ACC_W-1:0] opb = use_imm ? imm_ext : reg_b; // RL2
  wire [ACC_W-1:0] acc = gpr_q[dst_sel];
  wire signed [DATA_W-1:0] mul_a = opa[2*DATA_W-1:DATA_W];
  wire signed [DATA_W-1:0] mul_b = reg_b[2*DATA_W-1:DATA_W];
  wire signed [2*DATA_W-1:0] prod = mul_a * mul_b;
  wire [ACC_W-1:0] prod_ext = {{(ACC_W-2*DATA_W){prod[2*DATA_W-1]}}, prod};
  wire [4:0] shamt = opb[4:0];

  // execution units, with one spare bit for overflow detection
  logic [ACC_W:0] alu_wide;
  logic [ACC_W-1:0] exe;
  logic exe_ov;
  always_comb begin
    alu_wide = {(ACC_W+1){1'b0}};
    exe = acc;
    exe_ov = 1'b0;
    case (op)
      DOPU_OP_MAC_ADD: alu_wide = {acc[ACC_W-1], acc} + {prod_ext[ACC_W-1], prod_ext}; // RL1
      DOPU_OP_MAC_SUB: alu_wide = {acc[ACC_W-1], acc} - {prod_ext[ACC_W-1], prod_ext}; // RL1
      DOPU_OP_MUL: alu_wide = {prod_ext[ACC_W-1], prod_ext}; // RL2
      DOPU_OP_ADD: alu_wide = {opa[ACC_W-1], opa} + {opb[ACC_W-1], opb}; // RL2
      DOPU_OP_SUB: alu_wide = {opa[ACC_W-1], opa} - {opb[ACC_W-1], opb}; // RL2
      DOPU_OP_NEG: alu_wide = {(ACC_W+1){1'b0}} - {opa[ACC_W-1], opa}; // RL3
      DOPU_OP_INC: alu_wide = {opa[ACC_W-1], opa} + {{ACC_W{1'b0}}, 1'b1}; // RL3
      default: alu_wide = {acc[ACC_W-1], acc};
    endcase
    case (op)
      DOPU_OP_SRA: exe = $signed(opa) >>> shamt; // RL2
      DOPU_OP_SRL: exe = opa >> shamt; // RL2
      DOPU_OP_SLL: exe = opa << shamt; // RL2
      default: begin
        exe = alu_wide[ACC_W-1:0];
        exe_ov = alu_wide[ACC_W] ^ alu_wide[ACC_W-1]; // RL14
      end
    endcase
  end

  // pointer group and address selection
  wire ptr_is_y = (ptr_sel > 3'(`DOPU_PTR_X_LAST)); // RL7
  wire [PTR_W-1:0] dp = address_pointer_reg[ptr_sel];
  wire [PTR_W-1:0] dn = pointer_index_reg[ptr_sel];
  wire [PTR_W-1:0] modv = ptr_is_y ? y_modulo_reg : x_modulo_reg; // RL7
  logic [PTR_W-1:0] dp_rev;
  always_comb begin
    for (int i = 0; i < PTR_W; i++) begin
      dp_rev[i] = dp[PTR_W-1-i];
    end
  end
  wire [PTR_W-1:0] bit_reversed_addressing_mode = dp_rev; // RL12
  wire [PTR_W-1:0] acc_addr = (pmode == DOPU_PM_BITREV) ? bit_reversed_addressing_mode : dp; // RL9 RL12

  // modulo: low part spans the modulo register's significant bits
  logic [PTR_W-1:0] low_mask;
  always_comb begin
    low_mask = {PTR_W{1'b0}};
    for (int i = 0; i < PTR_W; i++) begin
      if ((modv >> i) != {PTR_W{1'b0}}) begin
        low_mask[i] = 1'b1;
      end
    end
  end
  wire [PTR_W-1:0] pointer_low_part = dp & low_mask;
  wire [PTR_W-1:0] pointer_high_part = dp & ~low_mask;
  wire [PTR_W:0] mod_base = {1'b0, modv} + {{PTR_W{1'b0}}, 1'b1};
  wire [PTR_W:0] low_sum = {1'b0, pointer_low_part} + {1'b0, dn};
  wire [PTR_W:0] low_mod = low_sum % mod_base; // RL11
  wire [PTR_W-1:0] modulo_addressing_mode = pointer_high_part | (low_mod[PTR_W-1:0] & low_mask); // RL11

  // post-access pointer value; adders wrap at pointer width
  logic [PTR_W-1:0] dp_next;
  always_comb begin
    case (pmode)
      DOPU_PM_INC: dp_next = dp + 16'h0001; // RL10 RL17
      DOPU_PM_DEC: dp_next = dp - 16'h0001; // RL10 RL17
      DOPU_PM_INDEX: dp_next = dp + dn; // RL10 RL17
      DOPU_PM_MODULO: dp_next = modulo_addressing_mode; // RL11
      DOPU_PM_BITREV: dp_next = dp + dn; // RL12
      default: dp_next = dp; // RL9
    endcase
  end
  wire is_mem = insn_valid && (op == DOPU_OP_LOAD || op == DOPU_OP_STORE); // RL4
  wire is_pmod = insn_valid && (op == DOPU_OP_PMOD);
  wire is_seti = insn_valid && (op == DOPU_OP_SETI);
  wire is_arith = insn_valid && (op inside {DOPU_OP_MAC_ADD, DOPU_OP_MAC_SUB, DOPU_OP_MUL, DOPU_OP_ADD,
    DOPU_OP_SUB, DOPU_OP_SRA, DOPU_OP_SRL, DOPU_OP_SLL, DOPU_OP_NEG, DOPU_OP_INC});

  // register write value per instruction class
  logic [ACC_W-1:0] gpr_wdata;
  always_comb begin
    case (op)
      DOPU_OP_LOAD: gpr_wdata = {{(ACC_W-2*DATA_W){mem_rdata[DATA_W-1]}}, mem_rdata, {DATA_W{1'b0}}}; // RL4
      DOPU_OP_MOVE: gpr_wdata = opa; // RL5
      DOPU_OP_SETI: gpr_wdata = imm_ext; // RL6
      default: gpr_wdata = exe;
    endcase
  end
  wire gpr_we = is_arith || (insn_valid && op == DOPU_OP_LOAD) || (insn_valid && op == DOPU_OP_MOVE) ||
    (is_seti && seti_dest == DOPU_SEL_GPR);

  // general registers: every instruction retires in one cycle
  generate
    for (genvar g = 0; g < NR; g++) begin : g_gpr
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          gpr_q[g] <= `DOPU_RESET_ACC;
        end else if (gpr_we && dst_sel == 3'(g)) begin
          gpr_q[g] <= gpr_wdata; // RL16
        end
      end
    end
  endgenerate

  // pointers and index registers; update lands after this cycle's access
  generate
    for (genvar p = 0; p < NP; p++) begin : g_ptr
      wire sel = (ptr_sel == 3'(p));
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          address_pointer_reg[p] <= `DOPU_RESET_DATA;
          pointer_index_reg[p] <= `DOPU_RESET_DATA;
        end else if (sel && is_mem) begin
          address_pointer_reg[p] <= dp_next; // RL8
        end else if (sel && is_pmod) begin
          address_pointer_reg[p] <= dp + imm; // RL13 RL17
        end else if (sel && is_seti && seti_dest == DOPU_SEL_PTR) begin
          address_pointer_reg[p] <= imm; // RL6
        end else if (sel && is_seti && seti_dest == DOPU_SEL_IDX) begin
          pointer_index_reg[p] <= imm; // RL6
        end
      end
    end
  endgenerate

  // modulo registers loaded by immediate setting only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      x_modulo_reg <= `DOPU_RESET_DATA;
      y_modulo_reg <= `DOPU_RESET_DATA;
    end else if (is_seti && seti_dest == DOPU_SEL_MOD) begin
      if (seti_mod_y) y_modulo_reg <= imm; // RL6
      else x_modulo_reg <= imm; // RL6
    end
  end

  // sticky overflow: only sets, only the reset branch of this block clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflow_flag_q <= 1'b0;
    end else if (is_arith && affects_ov && exe_ov) begin
      overflow_flag_q <= 1'b1; // RL14 RL15
    end
  end

  // registered memory port and result view
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_addr_q <= `DOPU_RESET_DATA;
      mem_y_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= `DOPU_RESET_DATA;
      result_q <= `DOPU_RESET_ACC;
    end else begin
      mem_addr_q <= acc_addr; // RL9 RL12
      mem_y_q <= ptr_is_y; // RL7
      mem_we_q <= is_mem && op == DOPU_OP_STORE; // RL4
      mem_wdata_q <= acc[2*DATA_W-1:DATA_W]; // RL4
      result_q <= gpr_wdata;
    end
  end

  assign mem_addr = mem_addr_q;
  assign mem_y_space = mem_y_q;
  assign mem_we = mem_we_q;
  assign mem_wdata = mem_wdata_q;
  assign overflow_flag = overflow_flag_q;
  assign result = result_q;
endmodule

/* File: tb/dopu_core_checker.sv */
// Purpose: port-level checks of the operand and pointer unit
// Assumes: one instruction taken per rising edge, outputs one edge later
// Notes: bound into every dopu_core after the module
`timescale 1ns/1ps
module dopu_core_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic insn_valid,
  input wire dopu_pkg::dopu_op_t op,
  input wire logic affects_ov,
  input wire logic [2:0] ptr_sel,
  input wire dopu_pkg::dopu_pmode_t pmode,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic mem_y_space,
  input wire logic mem_we,
  input wire logic overflow_flag,
  input wire logic [39:0] result
);
  import dopu_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // decoded access kinds, so each property but AST_PLAIN and AST_INC stays on one line
  wire ld = insn_valid && op == DOPU_OP_LOAD;
  wire st = insn_valid && op == DOPU_OP_STORE;
  wire y_grp = ptr_sel[2];
  AST_WE_STORE: assert property (st |=> mem_we) else $error("store gave no write strobe");
  AST_WE_IDLE: assert property (!st |=> !mem_we) else $error("write strobe without store");
  AST_OV_STICKY: assert property (overflow_flag |=> overflow_flag) else $error("overflow flag cleared");
  AST_OV_UNAFF: assert property (!(insn_valid && affects_ov) |=> $stable(overflow_flag))
    else $error("overflow flag moved by unaffected op");
  AST_Y_SPACE: assert property ((ld || st) |=> mem_y_space == $past(y_grp)) else $error("wrong data space");
  AST_LOAD_VAL: assert property (ld |=> result[31:0] == {$past(mem_rdata), 16'h0000})
    else $error("load value not placed in high word");
  // plain access twice on one pointer must give the same address
  AST_PLAIN: assert property (ld && pmode == DOPU_PM_PLAIN ##1 ld && pmode == DOPU_PM_PLAIN && $stable(ptr_sel)
    |=> $stable(mem_addr)) else $error("plain form moved pointer");
  AST_INC: assert property (ld && pmode == DOPU_PM_INC ##1 ld && pmode != DOPU_PM_BITREV && $stable(ptr_sel)
    |=> mem_addr == $past(mem_addr) + 16'h0001) else $error("post increment not seen next");
endmodule
bind dopu_core dopu_core_checker dopu_core_checker_inst (.clk(clk), .resetn(resetn), .insn_valid(insn_valid),
  .op(op), .affects_ov(affects_ov), .ptr_sel(ptr_sel), .pmode(pmode), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
  .mem_y_space(mem_y_space), .mem_we(mem_we), .overflow_flag(overflow_flag), .result(result));

/* File: tb/tb_dopu_core.sv */
// Purpose: self-checking bench of the operand and pointer unit
// Assumes: inputs change at falling edges, outputs read at the next falling edge
// Notes: SETI MOD picks x or y modulo from ptr_sel bit 0 here
`timescale 1ns/1ps
module tb_dopu_core;
  import dopu_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, insn_valid = 1'b0, affects_ov = 1'b0, use_imm = 1'b0, seti_mod_y = 1'b0;
  logic [2:0] dst_sel = 3'h0, src_a_sel = 3'h0, src_b_sel = 3'h0, ptr_sel = 3'h0;
  logic [15:0] imm = 16'h0000, mem_rdata = 16'h0000, mem_addr, mem_wdata;
  dopu_op_t op = DOPU_OP_NOP;
  dopu_pmode_t pmode = DOPU_PM_PLAIN;
  dopu_dest_t seti_dest = DOPU_SEL_GPR;
  logic mem_y_space, mem_we, overflow_flag;
  logic [39:0] result;
  int error_cnt = 0, compares = 0, cyc = 0;
  dopu_core dopu_core_inst (.clk(clk), .resetn(resetn), .insn_valid(insn_valid), .op(op), .affects_ov(affects_ov),
    .dst_sel(dst_sel), .src_a_sel(src_a_sel), .src_b_sel(src_b_sel), .use_imm(use_imm), .imm(imm),
    .seti_dest(seti_dest), .ptr_sel(ptr_sel), .seti_mod_y(seti_mod_y), .pmode(pmode), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_y_space(mem_y_space), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .overflow_flag(overflow_flag), .result(result));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard: whole run needs well under 100 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(logic [39:0] got, logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one instruction from a falling edge to the next; outputs then settled
  task automatic ex(dopu_op_t o, logic [2:0] p, dopu_pmode_t m, logic [15:0] v);
    op = o;
    ptr_sel = p;
    pmode = m;
    imm = v;
    mem_rdata = v;
    insn_valid = 1'b1;
    @(negedge clk);
  endtask
  task automatic seti(dopu_dest_t d, logic [2:0] p, logic [15:0] v);
    seti_dest = d;
    seti_mod_y = p[0];
    ex(DOPU_OP_SETI, p, DOPU_PM_PLAIN, v);
  endtask
  task automatic la(logic [2:0] p, dopu_pmode_t m, logic [15:0] a);
    ex(DOPU_OP_LOAD, p, m, 16'h1234);
    chk(mem_addr, a);
  endtask
  task automatic t_inc_dec;
    seti(DOPU_SEL_PTR, 3'h3, 16'hFFFF);
    la(3'h3, DOPU_PM_PLAIN, 16'hFFFF);
    la(3'h3, DOPU_PM_INC, 16'hFFFF);
    la(3'h3, DOPU_PM_DEC, 16'h0000);
    la(3'h3, DOPU_PM_PLAIN, 16'hFFFF);
    chk(mem_y_space, 40'h0);
    $display("test inc_dec done");
  endtask
  task automatic t_index;
    seti(DOPU_SEL_PTR, 3'h4, 16'h0100);
    seti(DOPU_SEL_IDX, 3'h4, 16'h0010);
    la(3'h4, DOPU_PM_INDEX, 16'h0100);
    chk(mem_y_space, 40'h1);
    la(3'h4, DOPU_PM_PLAIN, 16'h0110);
    ex(DOPU_OP_PMOD, 3'h4, DOPU_PM_PLAIN, 16'hFFF0);
    la(3'h4, DOPU_PM_PLAIN, 16'h0100);
    // dropped instruction must leave the pointer alone
    insn_valid = 1'b0;
    op = DOPU_OP_SETI;
    seti_dest = DOPU_SEL_PTR;
    @(negedge clk);
    la(3'h4, DOPU_PM_PLAIN, 16'h0100);
    $display("test index done");
  endtask
  task automatic t_modulo;
    seti(DOPU_SEL_MOD, 3'h0, 16'h0007);
    seti(DOPU_SEL_MOD, 3'h1, 16'h0003);
    seti(DOPU_SEL_PTR, 3'h0, 16'h0105);
    seti(DOPU_SEL_IDX, 3'h0, 16'h0002);
    seti(DOPU_SEL_PTR, 3'h5, 16'h0202);
    seti(DOPU_SEL_IDX, 3'h5, 16'h0003);
    la(3'h0, DOPU_PM_MODULO, 16'h0105);
    la(3'h0, DOPU_PM_MODULO, 16'h0107);
    la(3'h0, DOPU_PM_PLAIN, 16'h0101);
    la(3'h5, DOPU_PM_MODULO, 16'h0202);
    la(3'h5, DOPU_PM_PLAIN, 16'h0201);
    seti(DOPU_SEL_PTR, 3'h2, 16'h0001);
    seti(DOPU_SEL_IDX, 3'h2, 16'h0004);
    la(3'h2, DOPU_PM_BITREV, 16'h8000);
    la(3'h2, DOPU_PM_PLAIN, 16'h0005);
    $display("test modulo done");
  endtask
  task automatic t_move_store;
    dst_sel = 3'h2;
    ex(DOPU_OP_LOAD, 3'h0, DOPU_PM_PLAIN, 16'hA5C3);
    chk(result, 40'hFFA5C30000);
    src_a_sel = 3'h2;
    dst_sel = 3'h3;
    ex(DOPU_OP_MOVE, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'hFFA5C30000);
    ex(DOPU_OP_STORE, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(mem_we, 40'h1);
    chk(mem_wdata, 40'hA5C3);
    $display("test move_store done");
  endtask
  task automatic t_overflow;
    dst_sel = 3'h1;
    ex(DOPU_OP_LOAD, 3'h0, DOPU_PM_PLAIN, 16'h7FFF);
    src_a_sel = 3'h1;
    src_b_sel = 3'h1;
    use_imm = 1'b1;
    affects_ov = 1'b1;
    ex(DOPU_OP_SLL, 3'h0, DOPU_PM_PLAIN, 16'h0008);
    chk(overflow_flag, 40'h0);
    use_imm = 1'b0;
    affects_ov = 1'b0;
    dst_sel = 3'h4;
    ex(DOPU_OP_ADD, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(overflow_flag, 40'h0);
    affects_ov = 1'b1;
    ex(DOPU_OP_ADD, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(overflow_flag, 40'h1);
    src_a_sel = 3'h5;
    src_b_sel = 3'h5;
    ex(DOPU_OP_ADD, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(overflow_flag, 40'h1);
    $display("test overflow done");
  endtask
  // every execution unit once; two plain loads in a row on one pointer
  task automatic t_arith;
    affects_ov = 1'b0;
    use_imm = 1'b0;
    dst_sel = 3'h6;
    ex(DOPU_OP_LOAD, 3'h0, DOPU_PM_PLAIN, 16'h0003);
    dst_sel = 3'h7;
    ex(DOPU_OP_LOAD, 3'h0, DOPU_PM_PLAIN, 16'hFFFE);
    chk(result, 40'hFFFFFE0000);
    src_a_sel = 3'h6;
    src_b_sel = 3'h7;
    dst_sel = 3'h0;
    ex(DOPU_OP_MUL, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'hFFFFFFFFFA);
    src_b_sel = 3'h6;
    ex(DOPU_OP_MAC_ADD, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'h0000000003);
    src_b_sel = 3'h7;
    ex(DOPU_OP_MAC_SUB, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'h0000000009);
    dst_sel = 3'h5;
    ex(DOPU_OP_SUB, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'h0000050000);
    use_imm = 1'b1;
    ex(DOPU_OP_SUB, 3'h0, DOPU_PM_PLAIN, 16'h0001);
    chk(result, 40'h000002FFFF);
    src_a_sel = 3'h7;
    ex(DOPU_OP_SRA, 3'h0, DOPU_PM_PLAIN, 16'h0004);
    chk(result, 40'hFFFFFFE000);
    // shift count from register 0, which holds 9 here
    use_imm = 1'b0;
    src_b_sel = 3'h0;
    ex(DOPU_OP_SRL, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'h007FFFFF00);
    src_a_sel = 3'h6;
    ex(DOPU_OP_NEG, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'hFFFFFD0000);
    ex(DOPU_OP_INC, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'h0000030001);
    dst_sel = 3'h2;
    seti(DOPU_SEL_GPR, 3'h0, 16'h8001);
    chk(result, 40'hFFFFFF8001);
    src_a_sel = 3'h2;
    dst_sel = 3'h3;
    ex(DOPU_OP_MOVE, 3'h0, DOPU_PM_PLAIN, 16'h0000);
    chk(result, 40'hFFFFFF8001);
    chk(overflow_flag, 40'h1);
    $display("test arith done");
  endtask
  // mid-run reset: only reset clears the flag; first instruction taken at once
  task automatic t_reset;
    insn_valid = 1'b0;
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    chk(overflow_flag, 40'h0);
    la(3'h3, DOPU_PM_INC, 16'h0000);
    la(3'h3, DOPU_PM_PLAIN, 16'h0001);
    $display("test reset done");
  endtask
  // reset for two cycles, then the scenarios back to back
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_inc_dec();
    t_index();
    t_modulo();
    t_move_store();
    t_overflow();
    t_arith();
    t_reset();
    insn_valid = 1'b0;
    give_verdict();
  end
endmodule
